// ### hdl/csa_core.sv
// Stack pointer, status word and operand address resolution unit.
`timescale 1ns/10ps
`default_nettype none
module csa_core
  import csa_pkg::*;
(
  input  wire logic            CLK,
  input  wire logic            SRST,
  input  wire logic            CMD_VALID,
  input  wire csa_cmd_t        CMD,
  input  wire logic [15:0]     PC_NEXT,
  input  wire logic            FLAG_WE,
  input  wire csa_flags_t      FLAG_IN,
  input  wire logic [7:0]      SFR_RDATA,
  output logic                 BUSY,
  output logic                 DONE,
  output logic [15:0]          RESULT,
  output logic [7:0]           STACK_POINTER,
  output logic [7:0]           PROCESSOR_STATUS_WORD,
  output logic                 SFR_RE,
  output logic                 SFR_WE,
  output logic [7:0]           SFR_ADDR,
  output logic [7:0]           SFR_WDATA
);

  typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_SFR, ST_READ} csa_state_t;

  csa_state_t  state,   next_state;
  csa_op_t     op,      next_op;
  logic [7:0]  tgt,     next_tgt;
  logic        tgt_sfr, next_tgt_sfr;
  logic [2:0]  bit_idx, next_bit_idx;
  logic [7:0]  data,    next_data;
  logic        bit_val, next_bit_val;
  logic [7:0]  stack_ptr,   next_stack_ptr;
  logic [7:0]  status_word, next_status_word;
  logic [15:0] result,  next_result;
  logic        done,    next_done;
  logic        sfr_re,  next_sfr_re;
  logic        sfr_we,  next_sfr_we;
  logic [7:0]  sfr_adr, next_sfr_adr;
  logic [7:0]  sfr_wd,  next_sfr_wd;

  logic        ram_we;
  logic [7:0]  ram_addr;
  logic [7:0]  ram_wdata;
  logic [7:0]  ram_rdata;

  logic        wr_go, wr_sfr, rd_go, rd_sfr;
  logic [7:0]  wr_adr, wr_val, rd_adr, rd_byte, mod_byte;

  // bank register address from current bank select
  function automatic logic [7:0] reg_addr(input logic [7:0] status, input logic [2:0] n);
    reg_addr = {3'b000, status[STATUS_BANK_LO+1:STATUS_BANK_LO], n};
  endfunction : reg_addr

  csa_ram #(
    .DEPTH (RAM_DEPTH)
  ) u_ram (
    .clk   (CLK),
    .addr  (ram_addr),
    .we    (ram_we),
    .wdata (ram_wdata),
    .rdata (ram_rdata)
  );

  always_comb begin
    next_state   = state;
    next_op      = op;
    next_tgt     = tgt;
    next_tgt_sfr = tgt_sfr;
    next_bit_idx = bit_idx;
    next_data    = data;
    next_bit_val = bit_val;
    next_stack_ptr   = stack_ptr;
    next_status_word = status_word;
    next_result  = result;
    next_done    = 1'b0;
    next_sfr_re  = 1'b0;
    next_sfr_we  = 1'b0;
    next_sfr_adr = sfr_adr;
    next_sfr_wd  = sfr_wd;
    ram_we       = 1'b0;
    ram_addr     = tgt;
    ram_wdata    = 8'h00;
    wr_go        = 1'b0;
    wr_sfr       = 1'b0;
    wr_adr       = 8'h00;
    wr_val       = 8'h00;
    rd_go        = 1'b0;
    rd_sfr       = 1'b0;
    rd_adr       = 8'h00;

    // arithmetic flag effects; an explicit status word write below wins
    if (FLAG_WE) begin
      next_status_word[STATUS_CY] = FLAG_IN.cy;
      next_status_word[STATUS_AC] = FLAG_IN.ac;
      next_status_word[STATUS_OV] = FLAG_IN.ov;
    end

    // byte seen by the access that finishes in ST_READ
    if (!tgt_sfr) begin
      rd_byte = ram_rdata;
    end else if (tgt == STACK_POINTER_ADR) begin
      rd_byte = stack_ptr;
    end else if (tgt == STATUS_WORD_ADR) begin
      rd_byte = status_word;
    end else begin
      rd_byte = SFR_RDATA;
    end
    mod_byte          = rd_byte;
    mod_byte[bit_idx] = bit_val;

    unique case (state)
      ST_IDLE: begin
        if (CMD_VALID) begin
          next_op      = CMD.op;
          next_data    = CMD.data;
          next_bit_val = CMD.bit_val;
          next_bit_idx = CMD.byte1[2:0];
          unique case (CMD.op)
            OP_PUSH: begin
              next_stack_ptr = stack_ptr + 8'h01;
              ram_we         = 1'b1;
              ram_addr       = stack_ptr + 8'h01;
              ram_wdata = CMD.data;
              next_done = 1'b1;
            end
            OP_POP: begin
              rd_go  = 1'b1;
              rd_adr = stack_ptr;
            end
            OP_RD_REG: begin
              rd_go  = 1'b1;
              rd_adr = reg_addr(status_word, CMD.byte1[2:0]);
            end
            OP_WR_REG: begin
              wr_go  = 1'b1;
              wr_adr = reg_addr(status_word, CMD.byte1[2:0]);
              wr_val = CMD.data;
            end
            OP_RD_DIR: begin
              rd_go  = 1'b1;
              rd_sfr = CMD.byte1[7];
              rd_adr = CMD.byte1;
            end
            OP_WR_DIR: begin
              wr_go  = 1'b1;
              wr_sfr = CMD.byte1[7];
              wr_adr = CMD.byte1;
              wr_val = CMD.data;
            end
            OP_RD_IND, OP_WR_IND: begin
              ram_addr   = reg_addr(status_word, {2'b00, CMD.byte1[0]});
              next_state = ST_PTR;
            end
            OP_RD_BIT, OP_WR_BIT: begin
              rd_go  = 1'b1;
              rd_sfr = CMD.byte1[7];
              rd_adr = csa_bit_byte(CMD.byte1);
            end
            OP_IMM8: begin
              next_result = {8'h00, CMD.byte1};
              next_done   = 1'b1;
            end
            OP_IMM16, OP_LONG: begin
              next_result = {CMD.byte1, CMD.byte2};
              next_done   = 1'b1;
            end
            OP_ABS: begin
              next_result = {PC_NEXT[15:11], CMD.byte1[2:0], CMD.byte2};
              next_done   = 1'b1;
            end
            OP_REL: begin
              next_result = PC_NEXT + {{8{CMD.byte1[7]}}, CMD.byte1};
              next_done   = 1'b1;
            end
            default: begin
              next_done = 1'b1;
            end
          endcase
        end
      end
      ST_PTR: begin
        if (op == OP_WR_IND) begin
          wr_go      = 1'b1;
          wr_adr     = ram_rdata;
          wr_val     = data;
          next_state = ST_IDLE;
        end else begin
          rd_go  = 1'b1;
          rd_adr = ram_rdata;
        end
      end
      ST_SFR: begin
        next_state = ST_READ;
      end
      ST_READ: begin
        next_state = ST_IDLE;
        next_done  = 1'b1;
        if (op == OP_WR_BIT) begin
          wr_go  = 1'b1;
          wr_sfr = tgt_sfr;
          wr_adr = tgt;
          wr_val = mod_byte;
        end else if (op == OP_RD_BIT) begin
          next_result = {15'h0000, rd_byte[bit_idx]};
        end else begin
          next_result = {8'h00, rd_byte};
        end
        if (op == OP_POP) begin
          next_stack_ptr = stack_ptr - 8'h01;
        end
      end
    endcase

    if (wr_go) begin
      next_done = 1'b1;
      if (!wr_sfr) begin
        ram_we    = 1'b1;
        ram_addr  = wr_adr;
        ram_wdata = wr_val;
      end else if (wr_adr == STACK_POINTER_ADR) begin
        next_stack_ptr = wr_val;
      end else if (wr_adr == STATUS_WORD_ADR) begin
        next_status_word = wr_val;
      end else begin
        next_sfr_we  = 1'b1;
        next_sfr_adr = wr_adr;
        next_sfr_wd  = wr_val;
      end
    end

    if (rd_go) begin
      next_tgt     = rd_adr;
      next_tgt_sfr = rd_sfr;
      ram_addr     = rd_adr;
      if (rd_sfr && rd_adr != STACK_POINTER_ADR && rd_adr != STATUS_WORD_ADR) begin
        next_sfr_re  = 1'b1;
        next_sfr_adr = rd_adr;
        next_state   = ST_SFR;
      end else begin
        next_state = ST_READ;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state   <= ST_IDLE;
      op      <= OP_PUSH;
      tgt     <= 8'h00;
      tgt_sfr <= 1'b0;
      bit_idx <= 3'h0;
      data    <= 8'h00;
      bit_val <= 1'b0;
      stack_ptr   <= STACK_POINTER_RST;
      status_word <= STATUS_WORD_RST;
      result  <= 16'h0000;
      done    <= 1'b0;
      sfr_re  <= 1'b0;
      sfr_we  <= 1'b0;
      sfr_adr <= 8'h00;
      sfr_wd  <= 8'h00;
      BUSY    <= 1'b0;
    end else begin
      state   <= next_state;
      op      <= next_op;
      tgt     <= next_tgt;
      tgt_sfr <= next_tgt_sfr;
      bit_idx <= next_bit_idx;
      data    <= next_data;
      bit_val <= next_bit_val;
      stack_ptr   <= next_stack_ptr;
      status_word <= next_status_word;
      result  <= next_result;
      done    <= next_done;
      sfr_re  <= next_sfr_re;
      sfr_we  <= next_sfr_we;
      sfr_adr <= next_sfr_adr;
      sfr_wd  <= next_sfr_wd;
      BUSY    <= (next_state != ST_IDLE);
    end
  end

  assign DONE                  = done;
  assign RESULT                = result;
  assign STACK_POINTER         = stack_ptr;
  assign PROCESSOR_STATUS_WORD = status_word;
  assign SFR_RE                = sfr_re;
  assign SFR_WE                = sfr_we;
  assign SFR_ADDR              = sfr_adr;
  assign SFR_WDATA             = sfr_wd;

endmodule : csa_core
`default_nettype wire

// ### hdl/csa_ram.sv
// Internal data memory, 256 bytes, registered read data.
`timescale 1ns/10ps
`default_nettype none
module csa_ram #(
  parameter int DEPTH = 256
) (
  input  wire logic       clk,
  input  wire logic [7:0] addr,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output var  logic [7:0] rdata
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule : csa_ram
`default_nettype wire

// ### shared/csa_pkg.sv
// Shared constants, types and helpers for the stack and operand addressing unit.
package csa_pkg;

  localparam logic [7:0] STACK_POINTER_RST = 8'h07;
  localparam logic [7:0] STATUS_WORD_RST   = 8'h00;
  localparam logic [7:0] STACK_POINTER_ADR = 8'h81;
  localparam logic [7:0] STATUS_WORD_ADR   = 8'hd0;
  localparam int         STATUS_CY         = 7;
  localparam int         STATUS_AC         = 6;
  localparam int         STATUS_BANK_LO    = 3;
  localparam int         STATUS_OV         = 2;
  localparam logic [3:0] BIT_AREA_BASE     = 4'h2;
  localparam int         RAM_DEPTH         = 256;

  typedef enum logic [3:0] {
    OP_PUSH, OP_POP, OP_RD_REG, OP_WR_REG, OP_RD_DIR, OP_WR_DIR,
    OP_RD_IND, OP_WR_IND, OP_RD_BIT, OP_WR_BIT, OP_IMM8, OP_IMM16,
    OP_LONG, OP_ABS, OP_REL
  } csa_op_t;

  typedef struct packed {
    csa_op_t    op;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] data;
    logic       bit_val;
  } csa_cmd_t;

  typedef struct packed {
    logic cy;
    logic ac;
    logic ov;
  } csa_flags_t;

  // byte that holds a directly addressed bit
  function automatic logic [7:0] csa_bit_byte(input logic [7:0] b);
    csa_bit_byte = b[7] ? {b[7:3], 3'b000} : {BIT_AREA_BASE, b[6:3]};
  endfunction : csa_bit_byte

endpackage : csa_pkg

// ### tb/csa_core_properties.sv
// Checker of stack pointer, status word and operand results.
`timescale 1ns/10ps
`default_nettype none
module csa_core_properties
  import csa_pkg::*;
(
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic       CMD_VALID,
  input wire csa_cmd_t   CMD,
  input wire logic [15:0] PC_NEXT,
  input wire logic       FLAG_WE,
  input wire csa_flags_t FLAG_IN,
  input wire logic       BUSY,
  input wire logic       DONE,
  input wire logic [15:0] RESULT,
  input wire logic [7:0] STACK_POINTER,
  input wire logic [7:0] PROCESSOR_STATUS_WORD,
  input wire logic       SFR_RE,
  input wire logic       SFR_WE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  logic tk;
  logic ext;
  assign tk  = CMD_VALID && !BUSY;
  assign ext = CMD.byte1[7] && CMD.byte1 != STACK_POINTER_ADR && CMD.byte1 != STATUS_WORD_ADR;
  property p_rst;
    disable iff (1'b0) SRST |=> STACK_POINTER == 8'h07 && PROCESSOR_STATUS_WORD == 8'h00;
  endproperty
  property p_push;
    tk && CMD.op == OP_PUSH |=> DONE && STACK_POINTER == $past(STACK_POINTER) + 8'h01;
  endproperty
  property p_pop;
    tk && CMD.op == OP_POP |=> BUSY ##1 DONE && STACK_POINTER == $past(STACK_POINTER, 2) - 8'h01;
  endproperty
  property p_wide;
    tk && CMD.op inside {OP_IMM16, OP_LONG} |=>
      DONE && RESULT == {$past(CMD.byte1), $past(CMD.byte2)};
  endproperty
  property p_abs;
    tk && CMD.op == OP_ABS |=>
      RESULT == {$past(PC_NEXT[15:11]), $past(CMD.byte1[2:0]), $past(CMD.byte2)};
  endproperty
  property p_rel;
    tk && CMD.op == OP_REL |=>
      RESULT == $past(PC_NEXT) + {{8{$past(CMD.byte1[7])}}, $past(CMD.byte1)};
  endproperty
  property p_ext_wr;
    tk && CMD.op == OP_WR_DIR && ext |=>
      SFR_WE && DONE && SFR_ADDR == $past(CMD.byte1) && SFR_WDATA == $past(CMD.data);
  endproperty
  property p_ext_rd;
    tk && CMD.op == OP_RD_DIR && ext |=> SFR_RE && SFR_ADDR == $past(CMD.byte1) ##2 DONE;
  endproperty
  property p_low_ram;
    tk && CMD.op inside {OP_RD_DIR, OP_WR_DIR} && !CMD.byte1[7] |=> (!SFR_RE && !SFR_WE)[*2];
  endproperty
  property p_ind_ram;
    tk && CMD.op inside {OP_RD_IND, OP_WR_IND} |=> (!SFR_RE && !SFR_WE)[*3];
  endproperty
  property p_flags;
    FLAG_WE && !BUSY && !CMD_VALID |=> PROCESSOR_STATUS_WORD[7] == $past(FLAG_IN.cy)
      && PROCESSOR_STATUS_WORD[6] == $past(FLAG_IN.ac) && PROCESSOR_STATUS_WORD[2] == $past(FLAG_IN.ov);
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  a_push: assert property (p_push) else $error("push pointer wrong");
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
  a_wide: assert property (p_wide) else $error("wide constant wrong");
  a_abs: assert property (p_abs) else $error("page target wrong");
  a_rel: assert property (p_rel) else $error("relative target wrong");
  a_ext_wr: assert property (p_ext_wr) else $error("sfr write wrong");
  a_ext_rd: assert property (p_ext_rd) else $error("sfr read wrong");
  a_low_ram: assert property (p_low_ram) else $error("low direct hit sfr");
  a_ind_ram: assert property (p_ind_ram) else $error("indirect hit sfr");
  a_flags: assert property (p_flags) else $error("flags not loaded");
  c_push: cover property (tk && CMD.op == OP_PUSH);
  c_pop: cover property (tk && CMD.op == OP_POP);
  c_ext: cover property (tk && CMD.op == OP_RD_DIR && ext);
endmodule : csa_core_properties
bind csa_core csa_core_properties u_props (
  .CLK                   (CLK),
  .SRST                  (SRST),
  .CMD_VALID             (CMD_VALID),
  .CMD                   (CMD),
  .PC_NEXT               (PC_NEXT),
  .FLAG_WE               (FLAG_WE),
  .FLAG_IN               (FLAG_IN),
  .BUSY                  (BUSY),
  .DONE                  (DONE),
  .RESULT                (RESULT),
  .STACK_POINTER         (STACK_POINTER),
  .PROCESSOR_STATUS_WORD (PROCESSOR_STATUS_WORD),
  .SFR_RE                (SFR_RE),
  .SFR_WE                (SFR_WE),
  .SFR_ADDR              (SFR_ADDR),
  .SFR_WDATA             (SFR_WDATA)
);
`default_nettype wire

// ### tb/csa_core_tb.sv
// Self-checking bench for the stack and operand addressing unit.
`timescale 1ns/10ps
`default_nettype none
module csa_core_tb
  import csa_pkg::*;
;
  logic        CLK = 1'b0;
  logic        SRST = 1'b1;
  logic        CMD_VALID = 1'b0;
  csa_cmd_t    CMD = '0;
  logic [15:0] PC_NEXT = 16'hf7fe;
  logic        FLAG_WE = 1'b0;
  csa_flags_t  FLAG_IN = '0;
  logic [7:0]  SFR_RDATA = 8'h00;
  logic        BUSY, DONE, SFR_RE, SFR_WE;
  logic [15:0] RESULT, r;
  logic [7:0]  STACK_POINTER, PROCESSOR_STATUS_WORD, SFR_ADDR, SFR_WDATA;
  int          n_errors = 0;
  int          n_tests = 0;
  always #20 CLK = ~CLK;
  // external register file: answers each read strobe with a value tied to its address
  always @(posedge CLK) begin
    if (SFR_RE) begin
      SFR_RDATA <= SFR_ADDR ^ 8'hcc;
    end
  end
  csa_core dut (
    .CLK                   (CLK),
    .SRST                  (SRST),
    .CMD_VALID             (CMD_VALID),
    .CMD                   (CMD),
    .PC_NEXT               (PC_NEXT),
    .FLAG_WE               (FLAG_WE),
    .FLAG_IN               (FLAG_IN),
    .SFR_RDATA             (SFR_RDATA),
    .BUSY                  (BUSY),
    .DONE                  (DONE),
    .RESULT                (RESULT),
    .STACK_POINTER         (STACK_POINTER),
    .PROCESSOR_STATUS_WORD (PROCESSOR_STATUS_WORD),
    .SFR_RE                (SFR_RE),
    .SFR_WE                (SFR_WE),
    .SFR_ADDR              (SFR_ADDR),
    .SFR_WDATA             (SFR_WDATA)
  );
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cmd(input csa_op_t o, input logic [7:0] b1, input logic [7:0] d,
                     input logic [7:0] b2 = 8'h00, input logic bv = 1'b0);
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD <= '{o, b1, b2, d, bv};
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    #1;
    for (int i = 0; i < 6 && DONE !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    if (DONE !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: command never finished", $time);
    end
    r = RESULT;
  endtask : cmd
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (3000) @(posedge CLK);
    n_errors++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
    #1;
    chk({STACK_POINTER, PROCESSOR_STATUS_WORD}, 16'h0700);
    cmd(OP_PUSH, 8'h00, 8'ha5);
    chk({8'h00, STACK_POINTER}, 16'h0008);
    cmd(OP_PUSH, 8'h00, 8'h5a);
    cmd(OP_RD_DIR, 8'h08, 8'h00);
    chk(r, 16'h00a5);
    cmd(OP_RD_DIR, STACK_POINTER_ADR, 8'h00);
    chk(r, 16'h0009);
    cmd(OP_POP, 8'h00, 8'h00);
    chk(r, 16'h005a);
    cmd(OP_POP, 8'h00, 8'h00);
    chk({r[7:0], STACK_POINTER}, 16'ha507);
    for (int k = 0; k < 4; k++) begin
      cmd(OP_WR_DIR, STATUS_WORD_ADR, 8'(k << 3));
      cmd(OP_WR_REG, 8'h05, 8'(8'h30 + k));
      cmd(OP_RD_DIR, 8'(k * 8 + 5), 8'h00);
      chk(r, 16'(8'h30 + k));
    end
    cmd(OP_WR_REG, 8'h01, 8'hc4);
    cmd(OP_WR_IND, 8'h01, 8'h77);
    cmd(OP_RD_IND, 8'h01, 8'h00);
    chk(r, 16'h0077);
    cmd(OP_RD_DIR, 8'h19, 8'h00);
    chk(r, 16'h00c4);
    cmd(OP_RD_REG, 8'h01, 8'h00);
    chk(r, 16'h00c4);
    cmd(OP_WR_DIR, 8'h90, 8'h3c);
    chk({SFR_ADDR, SFR_WDATA}, 16'h903c);
    cmd(OP_RD_DIR, 8'h90, 8'h00);
    chk(r, 16'h005c);
    cmd(OP_WR_DIR, 8'h7f, 8'h3c);
    cmd(OP_RD_DIR, 8'h7f, 8'h00);
    chk(r, 16'h003c);
    cmd(OP_WR_DIR, 8'h20, 8'h00);
    cmd(OP_WR_BIT, 8'h03, 8'h00, 8'h00, 1'b1);
    cmd(OP_RD_DIR, 8'h20, 8'h00);
    chk(r, 16'h0008);
    cmd(OP_RD_BIT, 8'h93, 8'h00);
    chk(r, 16'h0001);
    cmd(OP_WR_BIT, 8'h95, 8'h00, 8'h00, 1'b1);
    chk({SFR_ADDR, SFR_WDATA}, 16'h907c);
    @(posedge CLK);
    FLAG_WE <= 1'b1;
    FLAG_IN <= '{1'b1, 1'b0, 1'b1};
    @(posedge CLK);
    FLAG_WE <= 1'b0;
    #1;
    chk({8'h00, PROCESSOR_STATUS_WORD}, 16'h009c);
    cmd(OP_WR_BIT, 8'hd7, 8'h00);
    chk({8'h00, PROCESSOR_STATUS_WORD}, 16'h001c);
    cmd(OP_WR_DIR, STACK_POINTER_ADR, 8'hff);
    cmd(OP_PUSH, 8'h00, 8'h66);
    cmd(OP_RD_DIR, 8'h00, 8'h00);
    chk({r[7:0], STACK_POINTER}, 16'h6600);
    cmd(OP_IMM8, 8'h9a, 8'h00);
    chk(r, 16'h009a);
    cmd(OP_IMM16, 8'h12, 8'h00, 8'h34);
    chk(r, 16'h1234);
    cmd(OP_LONG, 8'hfe, 8'h00, 8'hdc);
    chk(r, 16'hfedc);
    cmd(OP_ABS, 8'hfd, 8'h00, 8'h21);
    chk(r, 16'hf521);
    cmd(OP_REL, 8'h80, 8'h00);
    chk(r, 16'hf77e);
    cmd(OP_REL, 8'h7f, 8'h00);
    chk(r, 16'hf87d);
    @(posedge CLK);
    SRST <= 1'b1;
    repeat (2) @(posedge CLK);
    SRST <= 1'b0;
    #1;
    chk({STACK_POINTER, PROCESSOR_STATUS_WORD}, 16'h0700);
    conclude();
  end
endmodule : csa_core_tb
`default_nettype wire
